/* mdbr_host.sv */
module mdbr_host import mdbr_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i,
  output mdbr_req_t reg_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req_o = '0;
  // hold one access through its taking edge, then idle with a changed pattern
  task automatic xfer(input logic w, input logic [6:0] a, input logic [1:0] b,
    input logic [15:0] d, output logic [15:0] q, output logic v);
    @(posedge clk_sys_i);
    #1 reg_req_o = '{w, !w, a, b, d};
    @(posedge clk_sys_i);
    #1 reg_req_o = '{1'b0, 1'b0, ~a, ~b, ~d};
    q = rd_data_i;
    v = rd_valid_i;
  endtask
endmodule // mdbr_host

/* mdbr_pkg.sv */
package mdbr_pkg;

  // system clock and internal sample clock
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SAMPLE_HZ = 2000;
  localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;

  // byte addresses of the register pairs
  localparam logic [6:0] ADDR_DV_Z_LOW = 7'h38;
  localparam logic [6:0] ADDR_DV_Z_HIGH = 7'h3a;
  localparam logic [6:0] ADDR_BIAS_X_LOW = 7'h40;
  localparam logic [6:0] ADDR_BIAS_X_HIGH = 7'h42;
  localparam logic [6:0] ADDR_BIAS_Y_LOW = 7'h44;
  localparam logic [6:0] ADDR_BIAS_Y_HIGH = 7'h46;
  localparam logic [6:0] ADDR_BIAS_Z_LOW = 7'h48;
  localparam logic [6:0] ADDR_BIAS_Z_HIGH = 7'h4a;
  localparam int unsigned BIAS_WORDS = 6;

  // values after reset and read value of unmapped addresses
  localparam logic [15:0] BIAS_RESET = 16'h0000;
  localparam logic [31:0] DV_RESET = 32'h0000_0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // two's-complement limits of the 32-bit formats
  localparam logic [31:0] FULL_POS = 32'h7fff_ffff;
  localparam logic [31:0] FULL_NEG = 32'h8000_0000;

  localparam int unsigned DEC_W = 11;
  localparam int unsigned ACC_W = 48;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } mdbr_req_t;

  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
  } mdbr_axes_t;

  function automatic logic [31:0] mdbr_sat32(input logic signed [ACC_W-1:0] v);
    logic [31:0] r;
    r = v[31:0];
    if (v > $signed({{(ACC_W-32){1'b0}}, FULL_POS})) begin
      r = FULL_POS;
    end else if (v < $signed({{(ACC_W-32){1'b1}}, FULL_NEG})) begin
      r = FULL_NEG;
    end
    return r;
  endfunction

endpackage

/* mdbr_regs.sv */
// Operation
// - upper velocity word: signed, +-400 m/s, zero=0
// - 16-bit scale: 0x7fff positive, 0x8000 is -400
// - low register carries 16 extra resolution bits
// - both words form one 32-bit signed value
// - velocity words read-only at 0x38 and 0x3a
// - host writes per-axis bias; factory math hidden
// - bias added right after factory correction stage
// - internal correction chain runs at 2000 Hz
// - bias low and high form 32-bit offset
// - bias low words at 0x40, 0x44, 0x48
// - bias high words at 0x42, 0x46, 0x4a
// - bias resets to zero, read-write, flash-backed
// - velocity is trapezoidal sum over the period
// - decimation count equals setting plus one
module mdbr_regs import mdbr_pkg::*; #(
  parameter int unsigned SAMPLE_DIV_P = SAMPLE_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire mdbr_req_t reg_req_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic [DEC_W-1:0] decimation_setting_i,
  input wire mdbr_axes_t gyro_factory_i,
  input wire logic [31:0] accel_z_factory_i,
  output mdbr_axes_t gyro_corr_o,
  output logic gyro_valid_o,
  output logic dv_ready_o,
  output logic sample_tick_o,
  input wire logic flash_restore_i,
  input wire mdbr_axes_t flash_image_i,
  output mdbr_axes_t flash_image_o
);

  // internal sample strobe
  logic tick_w;

  mdbr_tick #(
    .DIV(SAMPLE_DIV_P)
  ) u_tick (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .tick_o(tick_w)
  );

  // address decode
  wire logic [6:0] word_addr_w = {reg_req_i.addr[6:1], 1'b0};

  wire logic hit_dv_low_w = (word_addr_w == ADDR_DV_Z_LOW);
  wire logic hit_dv_high_w = (word_addr_w == ADDR_DV_Z_HIGH);
  wire logic hit_bxl_w = (word_addr_w == ADDR_BIAS_X_LOW);
  wire logic hit_bxh_w = (word_addr_w == ADDR_BIAS_X_HIGH);
  wire logic hit_byl_w = (word_addr_w == ADDR_BIAS_Y_LOW);
  wire logic hit_byh_w = (word_addr_w == ADDR_BIAS_Y_HIGH);
  wire logic hit_bzl_w = (word_addr_w == ADDR_BIAS_Z_LOW);
  wire logic hit_bzh_w = (word_addr_w == ADDR_BIAS_Z_HIGH);

  // one-hot select of the six bias words: x low, x high, y low, ...
  wire logic [BIAS_WORDS-1:0] bias_sel_w = {
    hit_bzh_w, hit_bzl_w, hit_byh_w, hit_byl_w, hit_bxh_w, hit_bxl_w
  };

  // writes to the velocity words and to unmapped addresses are dropped
  wire logic [BIAS_WORDS-1:0] bias_wr_w = bias_sel_w & {BIAS_WORDS{reg_req_i.wr}};

  // bias storage
  logic [15:0] bias_r [BIAS_WORDS];
  logic [15:0] bias_nxt [BIAS_WORDS];
  logic [15:0] restore_w [BIAS_WORDS];

  assign restore_w[0] = flash_image_i.x[15:0];
  assign restore_w[1] = flash_image_i.x[31:16];
  assign restore_w[2] = flash_image_i.y[15:0];
  assign restore_w[3] = flash_image_i.y[31:16];
  assign restore_w[4] = flash_image_i.z[15:0];
  assign restore_w[5] = flash_image_i.z[31:16];

  genvar gi;
  generate
    for (gi = 0; gi < BIAS_WORDS; gi++) begin : g_bias
      // a host write in the same cycle as a flash restore wins over it
      wire logic [15:0] base_w = flash_restore_i ? restore_w[gi] : bias_r[gi];
      wire logic [7:0] lo_w = (bias_wr_w[gi] && reg_req_i.be[0]) ?
                              reg_req_i.wdata[7:0] : base_w[7:0];
      wire logic [7:0] hi_w = (bias_wr_w[gi] && reg_req_i.be[1]) ?
                              reg_req_i.wdata[15:8] : base_w[15:8];

      assign bias_nxt[gi] = {hi_w, lo_w};

      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          bias_r[gi] <= BIAS_RESET;
        end else begin
          bias_r[gi] <= bias_nxt[gi];
        end
      end
    end
  endgenerate

  // each axis offset is its high word over its low word
  mdbr_axes_t bias_w;
  assign bias_w.x = {bias_r[1], bias_r[0]};
  assign bias_w.y = {bias_r[3], bias_r[2]};
  assign bias_w.z = {bias_r[5], bias_r[4]};

  // gyroscope correction: factory stage output plus user offset
  wire logic signed [ACC_W-1:0] gx_sum_w = ACC_W'($signed(gyro_factory_i.x))
                                         + ACC_W'($signed(bias_w.x));
  wire logic signed [ACC_W-1:0] gy_sum_w = ACC_W'($signed(gyro_factory_i.y))
                                         + ACC_W'($signed(bias_w.y));
  wire logic signed [ACC_W-1:0] gz_sum_w = ACC_W'($signed(gyro_factory_i.z))
                                         + ACC_W'($signed(bias_w.z));

  mdbr_axes_t gyro_corr_nxt;
  assign gyro_corr_nxt.x = mdbr_sat32(gx_sum_w);
  assign gyro_corr_nxt.y = mdbr_sat32(gy_sum_w);
  assign gyro_corr_nxt.z = mdbr_sat32(gz_sum_w);

  mdbr_axes_t gyro_corr_r;
  logic gyro_valid_r;
  logic tick_r;

  // the offset in force at each strobe is the one held before that edge,
  // so a write lands on the next processed sample
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gyro_corr_r <= '0;
      gyro_valid_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      gyro_valid_r <= tick_w;
      tick_r <= tick_w;
      if (tick_w) begin
        gyro_corr_r <= gyro_corr_nxt;
      end
    end
  end

  assign gyro_corr_o = gyro_corr_r;
  assign gyro_valid_o = gyro_valid_r;
  assign sample_tick_o = tick_r;

  // z-axis velocity change
  logic [31:0] dv_w;
  logic dv_done_w;

  mdbr_trap u_trap (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .sample_i(tick_w),
    .accel_i(accel_z_factory_i),
    .count_i(decimation_setting_i),
    .result_o(dv_w),
    .done_o(dv_done_w)
  );

  logic [15:0] dv_low_r;
  logic [15:0] dv_high_r;
  logic dv_ready_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dv_low_r <= DV_RESET[15:0];
      dv_high_r <= DV_RESET[31:16];
      dv_ready_r <= 1'b0;
    end else begin
      dv_ready_r <= dv_done_w;
      if (dv_done_w) begin
        dv_high_r <= dv_w[31:16];
        dv_low_r <= dv_w[15:0];
      end
    end
  end

  assign dv_ready_o = dv_ready_r;

  // flash image of the offsets
  mdbr_axes_t flash_image_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_image_r <= '0;
    end else begin
      flash_image_r <= bias_w;
    end
  end

  assign flash_image_o = flash_image_r;

  // read path: answer one cycle after the request
  wire logic [15:0] rd_word_w =
    hit_dv_low_w ? dv_low_r :
    hit_dv_high_w ? dv_high_r :
    hit_bxl_w ? bias_r[0] :
    hit_bxh_w ? bias_r[1] :
    hit_byl_w ? bias_r[2] :
    hit_byh_w ? bias_r[3] :
    hit_bzl_w ? bias_r[4] :
    hit_bzh_w ? bias_r[5] :
    UNMAPPED_READ;

  logic [15:0] rd_data_r;
  logic rd_valid_r;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        rd_data_r <= rd_word_w;
      end
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;

endmodule // mdbr_regs

/* mdbr_regs_properties.sv */
module mdbr_regs_properties import mdbr_pkg::*; #(
  parameter int unsigned SAMPLE_DIV_P = SAMPLE_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire mdbr_req_t reg_req_i,
  input wire logic [15:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic gyro_valid_o,
  input wire logic dv_ready_o,
  input wire logic sample_tick_o,
  input wire mdbr_axes_t flash_image_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  logic [15:0] gap_r;
  logic seen_r;
  logic mapped;
  assign mapped = {reg_req_i.addr[6:1], 1'b0} inside {ADDR_DV_Z_LOW, ADDR_DV_Z_HIGH,
    ADDR_BIAS_X_LOW, ADDR_BIAS_X_HIGH, ADDR_BIAS_Y_LOW, ADDR_BIAS_Y_HIGH,
    ADDR_BIAS_Z_LOW, ADDR_BIAS_Z_HIGH};
  // cycles since the last sample strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= sample_tick_o ? 16'h0001 : gap_r + 16'h0001;
      seen_r <= seen_r | sample_tick_o;
    end
  end
  a_read_answer_next: assert property (reg_req_i.rd |=> rd_valid_o)
    else $error("read not answered next cycle");
  a_valid_only_read: assert property (rd_valid_o |-> $past(reg_req_i.rd))
    else $error("read valid without a read");
  a_read_data_holds: assert property (!rd_valid_o |-> $stable(rd_data_o))
    else $error("read data moved without a read");
  a_unmapped_reads_zero: assert property (
    reg_req_i.rd && !mapped |=> rd_data_o == UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_tick_spacing: assert property (
    sample_tick_o && seen_r |-> gap_r == 16'(SAMPLE_DIV_P))
    else $error("sample strobe spacing wrong");
  a_gyro_with_tick: assert property (
    gyro_valid_o |-> sample_tick_o ##1 !gyro_valid_o)
    else $error("corrected rate not paired with strobe");
  a_dv_after_tick: assert property (dv_ready_o |-> $past(sample_tick_o))
    else $error("velocity update not after a strobe");
  a_offset_image: assert property (
    reg_req_i.wr && reg_req_i.addr == ADDR_BIAS_X_LOW && reg_req_i.be == 2'b11
    |-> ##2 flash_image_o.x[15:0] == $past(reg_req_i.wdata, 2))
    else $error("flash image missed offset write");
endmodule // mdbr_regs_properties

/* mdbr_tick.sv */
// free-running divider giving the internal sample strobe
module mdbr_tick import mdbr_pkg::*; #(
  parameter int unsigned DIV = SAMPLE_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  output logic tick_o
);

  logic [31:0] cnt_r;
  wire last_w = (cnt_r == 32'(DIV - 1));

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 32'h0000_0000;
      tick_o <= 1'b0;
    end else begin
      cnt_r <= last_w ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
      tick_o <= last_w;
    end
  end

endmodule // mdbr_tick

/* mdbr_trap.sv */
// trapezoidal integrator over a decimation period of count_i + 1 samples
module mdbr_trap import mdbr_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sample_i,
  input wire logic [31:0] accel_i,
  input wire logic [DEC_W-1:0] count_i,
  output logic [31:0] result_o,
  output logic done_o
);

  logic signed [ACC_W-1:0] acc_r;
  logic [31:0] prev_r;
  logic [DEC_W-1:0] cnt_r;

  wire logic signed [ACC_W-1:0] sum_w = acc_r + ACC_W'($signed(accel_i))
                                      + ACC_W'($signed(prev_r));
  wire logic end_w = (cnt_r >= count_i);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r <= '0;
      prev_r <= 32'h0000_0000;
      cnt_r <= '0;
      result_o <= DV_RESET;
      done_o <= 1'b0;
    end else begin
      done_o <= sample_i && end_w;
      if (sample_i) begin
        prev_r <= accel_i;
        if (end_w) begin
          result_o <= mdbr_sat32(sum_w >>> 1);
          acc_r <= '0;
          cnt_r <= '0;
        end else begin
          acc_r <= sum_w;
          cnt_r <= cnt_r + DEC_W'(1);
        end
      end
    end
  end

endmodule // mdbr_trap

/* tb_motion_delta_and_bias_regs.sv */
module tb_motion_delta_and_bias_regs import mdbr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [6:0] a; logic [1:0] b; logic [15:0] d; logic [15:0] e;} mdbr_row_t;
  typedef struct packed {logic [10:0] d; logic [31:0] a; logic [31:0] e;} mdbr_dv_t;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  mdbr_req_t req;
  logic [15:0] rd_data, q, h;
  logic rd_valid, gyro_valid, dv_ready, tick, restore;
  logic [DEC_W-1:0] dec;
  logic [31:0] accel;
  mdbr_axes_t gyro_in, corr, img_in, img_out;
  int err_count = 0;
  int compares = 0;
  mdbr_row_t rows [9] = '{'{7'h40, 2'b11, 16'h1234, 16'h1234},
    '{7'h43, 2'b11, 16'hfedc, 16'hfedc}, '{7'h44, 2'b01, 16'haa55, 16'h0055},
    '{7'h46, 2'b10, 16'haa55, 16'haa00}, '{7'h48, 2'b11, 16'h8000, 16'h8000},
    '{7'h4a, 2'b11, 16'h7fff, 16'h7fff}, '{7'h38, 2'b11, 16'hbeef, 16'h0000},
    '{7'h3a, 2'b11, 16'hbeef, 16'h0000}, '{7'h4c, 2'b11, 16'hbeef, 16'h0000}};
  mdbr_dv_t dvr [4] = '{'{11'h001, 32'h0000_c001, 32'h0001_8002},
    '{11'h000, 32'hc000_0000, 32'hc000_0000}, '{11'h001, 32'hc000_0000, 32'h8000_0000},
    '{11'h002, 32'h0000_0010, 32'h0000_0030}};
  always #20 clk_sys_i = ~clk_sys_i;
  mdbr_host u_mdbr_host (.clk_sys_i(clk_sys_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .reg_req_o(req));
  mdbr_regs #(.SAMPLE_DIV_P(20)) u_mdbr_regs (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .reg_req_i(req), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .decimation_setting_i(dec), .gyro_factory_i(gyro_in), .accel_z_factory_i(accel),
    .gyro_corr_o(corr), .gyro_valid_o(gyro_valid), .dv_ready_o(dv_ready),
    .sample_tick_o(tick), .flash_restore_i(restore), .flash_image_i(img_in),
    .flash_image_o(img_out));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [1:0] b, input logic [15:0] d);
    logic [15:0] x;
    logic v;
    u_mdbr_host.xfer(1'b1, a, b, d, x, v);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] x);
    logic v;
    u_mdbr_host.xfer(1'b0, a, 2'b00, 16'h0000, x, v);
    check({31'h0, v}, 32'h1);
  endtask
  task automatic wait_sig(input logic dvw);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (!(dvw ? dv_ready : gyro_valid) && n < 200);
    if (n >= 200) check(32'h0, 32'h1);
  endtask
  initial begin
    dec = '0;
    accel = '0;
    gyro_in = '0;
    img_in = '0;
    restore = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, q);
      check({16'h0, q}, 32'h0);
      wr(rows[i].a, rows[i].b, rows[i].d);
      rd(rows[i].a, q);
      check({16'h0, q}, {16'h0, rows[i].e});
    end
    gyro_in = '{32'h0000_0064, 32'h55ff_ffab, 32'h7fff_fff0};
    wr(ADDR_BIAS_X_LOW, 2'b11, 16'hfff6);
    wr(ADDR_BIAS_X_HIGH, 2'b11, 16'hffff);
    wr(ADDR_BIAS_Z_LOW, 2'b11, 16'h0100);
    wr(ADDR_BIAS_Z_HIGH, 2'b11, 16'h0000);
    repeat (2) wait_sig(1'b0);
    check({31'h0, tick}, 32'h1);
    check(corr.x, 32'h0000_005a);
    check(corr.y, 32'h0000_0000);
    check(corr.z, 32'h7fff_ffff);
    check(img_out.z, 32'h0000_0100);
    img_in = '{32'h0102_0304, 32'h0, 32'h0};
    restore = 1'b1;
    @(posedge clk_sys_i);
    #1 restore = 1'b0;
    rd(ADDR_BIAS_X_HIGH, q);
    check({16'h0, q}, 32'h0000_0102);
    foreach (dvr[i]) begin
      dec = dvr[i].d;
      accel = dvr[i].a;
      repeat (3) wait_sig(1'b1);
      rd(ADDR_DV_Z_HIGH, h);
      rd(ADDR_DV_Z_LOW, q);
      check({h, q}, dvr[i].e);
    end
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    rd(ADDR_BIAS_X_LOW, q);
    check({16'h0, q}, 32'h0);
    stop_test();
  end
  initial begin
    #(40 * 5000);
    check(32'h0, 32'h1);
    stop_test();
  end
endmodule // tb_motion_delta_and_bias_regs
bind mdbr_regs mdbr_regs_properties #(.SAMPLE_DIV_P(SAMPLE_DIV_P)) u_props (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i), .rd_data_o(rd_data_o),
  .rd_valid_o(rd_valid_o), .gyro_valid_o(gyro_valid_o), .dv_ready_o(dv_ready_o),
  .sample_tick_o(sample_tick_o), .flash_image_o(flash_image_o));
